// File: src/rdf_consts.svh
`ifndef RDF_CONSTS_SVH
`define RDF_CONSTS_SVH

// ============================================================
// Buffer geometry
`define RDF_DEPTH      7'h40
`define RDF_AW         6
`define RDF_CW         7
`define RDF_PTR_ONE    6'h01
`define RDF_CNT_ONE    7'h01
`define RDF_CNT_ZERO   7'h00

// ============================================================
// Threshold coding
`define RDF_THR_STEP   7'h04
`define RDF_TX_THR_TOP 7'h3d

// ============================================================
// Output pin select codes
`define RDF_SEL_RX_THR 6'h00
`define RDF_SEL_TX_THR 6'h02

// ============================================================
// Serial port framing
`define RDF_FIFO_ADDR  6'h3f
`define RDF_BIT_FIRST  3'h0
`define RDF_BIT_STATUS 3'h1
`define RDF_BIT_LAST   3'h7
`define RDF_BIT_ONE    3'h1
`define RDF_HDR_RW     7
`define RDF_HDR_BURST  6

`endif

// File: src/rdf_pkg.sv
`default_nettype none

package rdf_pkg;

  // Phase of a serial transaction
  typedef enum logic [1:0] {
    RDF_PH_HDR,
    RDF_PH_DATA
  } rdf_phase_t;

endpackage : rdf_pkg

`default_nettype wire

// File: src/rdf_mem.sv
`include "rdf_consts.svh"
`default_nettype none

module rdf_mem (
  input  wire logic              i_clk,   // Core clock
  input  wire logic              i_we,    // Write strobe
  input  wire logic [`RDF_AW-1:0] i_waddr, // Write address
  input  wire logic [7:0]        i_wdata, // Write byte
  input  wire logic [`RDF_AW-1:0] i_raddr, // Read address, next head
  output logic      [7:0]        o_rdata  // Registered read byte
);

  logic [7:0] mem [0:63];
  logic [7:0] next_rdata;

  // ============================================================
  // Read with bypass so a byte written into an empty buffer is
  // seen at once
  always_comb begin
    if (i_we && (i_waddr == i_raddr)) begin
      next_rdata = i_wdata;
    end else begin
      next_rdata = mem[i_raddr];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= next_rdata;
  end

endmodule : rdf_mem

`default_nettype wire

// File: src/rdf_top.sv
// Operation
// - Two independent 64-byte buffers, one receive and one transmit.
// - Serial reads drain receive buffer, serial writes fill transmit buffer.
// - Detect receive overflow on full write, transmit underflow on empty read.
// - Header status byte carries receive fill on read, transmit on write.
// - Receive and transmit byte counts are readable status outputs.
// - A 4-bit field picks one of 16 thresholds for both buffers.
// - Receive threshold 4*(s+1); transmit threshold 61-4*s.
// - Threshold flag high when count at or above threshold.
// - Select 0x00 shows receive flag, 0x02 transmit flag on output pin.
// - Entering sleep discards all buffer contents.
`include "rdf_consts.svh"
`default_nettype none

module rdf_top (
  input  wire logic              i_clk,          // Core clock
  input  wire logic              i_rstn,         // Async reset, low
  input  wire logic              i_csn,          // Serial select, low
  input  wire logic              i_sclk,         // Serial clock
  input  wire logic              i_si,           // Serial data in
  output logic                   o_so,           // Serial data out
  output logic                   o_so_oe,        // Serial out enable
  input  wire logic              i_rx_wr_valid,  // Modem byte received
  input  wire logic [7:0]        i_rx_wr_data,   // Received byte
  input  wire logic              i_tx_rd_req,    // Modem wants a byte
  output logic      [7:0]        o_tx_rd_data,   // Byte to send
  output logic                   o_tx_rd_valid,  // Byte given, pulse
  input  wire logic              i_rx_flush,     // Empty receive buffer
  input  wire logic              i_tx_flush,     // Empty transmit buffer
  input  wire logic              i_sleep,        // Sleep state
  input  wire logic [3:0]        i_threshold_select_field, // Threshold
  input  wire logic [5:0]        i_output_pin_signal_select, // Pin sel
  output logic                   o_general_purpose_output_pin, // Pin
  output logic [`RDF_CW-1:0]     o_receive_byte_count,  // Rx fill
  output logic [`RDF_CW-1:0]     o_transmit_byte_count, // Tx fill
  output logic                   o_rx_overflow,  // Sticky overflow
  output logic                   o_tx_underflow  // Sticky underflow
);

  // ============================================================
  // Functions
  function automatic logic [`RDF_AW-1:0] rdf_inc(
    input logic [`RDF_AW-1:0] p,
    input logic               en
  );
    rdf_inc = en ? p + `RDF_PTR_ONE : p;
  endfunction : rdf_inc

  function automatic logic [`RDF_CW-1:0] rdf_count(
    input logic [`RDF_CW-1:0] c,
    input logic               push,
    input logic               pop
  );
    logic [`RDF_CW-1:0] r;
    r = c;
    if (push && !pop) begin
      r = c + `RDF_CNT_ONE;
    end else if (pop && !push) begin
      r = c - `RDF_CNT_ONE;
    end
    rdf_count = r;
  endfunction : rdf_count

  // ============================================================
  // Pin synchronisers
  logic csn_s1, csn_s2, sclk_s1, sclk_s2, sclk_s3, si_s1, si_s2;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      csn_s1  <= 1'b1;
      csn_s2  <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      si_s1   <= 1'b0;
      si_s2   <= 1'b0;
    end else begin
      csn_s1  <= i_csn;
      csn_s2  <= csn_s1;
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      si_s1   <= i_si;
      si_s2   <= si_s1;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = !csn_s2 && sclk_s2 && !sclk_s3;
  assign sclk_fall = !csn_s2 && !sclk_s2 && sclk_s3;

  // ============================================================
  // State
  rdf_pkg::rdf_phase_t phase, next_phase;
  logic [2:0]          bitcnt, next_bitcnt;
  logic [7:0]          sh_in, next_sh_in, sh_out, next_sh_out;
  logic                is_read, next_is_read;
  logic                is_fifo, next_is_fifo;
  logic                is_burst, next_is_burst;
  logic                served, next_served;
  logic [`RDF_AW-1:0]  rx_wp, next_rx_wp, rx_rp, next_rx_rp;
  logic [`RDF_AW-1:0]  tx_wp, next_tx_wp, tx_rp, next_tx_rp;
  logic [`RDF_CW-1:0]  rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
  logic                rx_ovf, next_rx_ovf, tx_unf, next_tx_unf;
  logic [7:0]          next_tx_data;
  logic                next_tx_valid, next_gpo;

  logic       rx_push, rx_pop, tx_push, tx_pop;
  logic       rx_ovf_ev, tx_unf_ev, rx_clr, tx_clr;
  logic [7:0] rx_head, tx_head, hdr_byte, tx_wbyte;
  logic [`RDF_CW-1:0] rx_thr, tx_thr;
  logic       rx_flag, tx_flag;

  // ============================================================
  // Buffers
  rdf_mem u_rx_mem (
    .i_clk   (i_clk),
    .i_we    (rx_push),
    .i_waddr (rx_wp),
    .i_wdata (i_rx_wr_data),
    .i_raddr (next_rx_rp),
    .o_rdata (rx_head)
  );

  rdf_mem u_tx_mem (
    .i_clk   (i_clk),
    .i_we    (tx_push),
    .i_waddr (tx_wp),
    .i_wdata (tx_wbyte),
    .i_raddr (next_tx_rp),
    .o_rdata (tx_head)
  );

  // ============================================================
  // Thresholds
  assign rx_thr = (`RDF_CW'(i_threshold_select_field) + `RDF_CNT_ONE)
                  * `RDF_THR_STEP;
  assign tx_thr = `RDF_TX_THR_TOP
                  - `RDF_CW'(i_threshold_select_field) * `RDF_THR_STEP;
  assign rx_flag = rx_cnt >= rx_thr;
  assign tx_flag = tx_cnt >= tx_thr;

  // ============================================================
  // Next-state logic
  always_comb begin
    next_phase    = phase;
    next_bitcnt   = bitcnt;
    next_sh_in    = sh_in;
    next_sh_out   = sh_out;
    next_is_read  = is_read;
    next_is_fifo  = is_fifo;
    next_is_burst = is_burst;
    next_served   = served;
    hdr_byte      = {sh_in[6:0], si_s2};
    tx_wbyte      = hdr_byte;
    rx_pop        = 1'b0;
    tx_push       = 1'b0;

    // Modem side; a full receive buffer drops the byte
    rx_ovf_ev = i_rx_wr_valid && (rx_cnt == `RDF_DEPTH);
    rx_push   = i_rx_wr_valid && !rx_ovf_ev;
    tx_unf_ev = i_tx_rd_req && (tx_cnt == `RDF_CNT_ZERO);
    tx_pop    = i_tx_rd_req && !tx_unf_ev;

    if (csn_s2) begin
      next_phase  = rdf_pkg::RDF_PH_HDR;
      next_bitcnt = `RDF_BIT_FIRST;
      next_sh_out = 8'h00;
      next_served = 1'b0;
    end else if (sclk_rise) begin
      next_sh_in  = hdr_byte;
      next_bitcnt = bitcnt + `RDF_BIT_ONE;
      if (phase == rdf_pkg::RDF_PH_HDR && bitcnt == `RDF_BIT_FIRST) begin
        next_is_read = si_s2;
      end
      if (bitcnt == `RDF_BIT_LAST) begin
        case (phase)
          rdf_pkg::RDF_PH_HDR: begin
            next_is_burst = hdr_byte[`RDF_HDR_BURST];
            next_is_fifo  = hdr_byte[5:0] == `RDF_FIFO_ADDR;
            next_phase    = rdf_pkg::RDF_PH_DATA;
          end
          default: begin
            if (is_fifo && (is_burst || !served)) begin
              next_served = 1'b1;
              if (!is_read) begin
                // Overfilling is the host's fault; drop to keep pointers
                tx_push = tx_cnt != `RDF_DEPTH;
              end else begin
                // Byte fully shifted out, only now leaves the buffer
                rx_pop = rx_cnt != `RDF_CNT_ZERO;
              end
            end
          end
        endcase
      end
    end else if (sclk_fall) begin
      if (phase == rdf_pkg::RDF_PH_HDR && bitcnt == `RDF_BIT_STATUS) begin
        next_sh_out = is_read ? {rx_cnt, 1'b0} : {tx_cnt, 1'b0};
      end else if (phase == rdf_pkg::RDF_PH_DATA
                   && bitcnt == `RDF_BIT_FIRST) begin
        if (is_fifo && is_read && (is_burst || !served)) begin
          next_sh_out = rx_head;
        end else begin
          next_sh_out = 8'h00;
        end
      end else begin
        next_sh_out = {sh_out[6:0], 1'b0};
      end
    end

    // Sleep discards everything; flush empties one buffer
    rx_clr = i_sleep || i_rx_flush;
    tx_clr = i_sleep || i_tx_flush;

    if (rx_clr) begin
      next_rx_wp  = '0;
      next_rx_rp  = '0;
      next_rx_cnt = `RDF_CNT_ZERO;
    end else begin
      next_rx_wp  = rdf_inc(rx_wp, rx_push);
      next_rx_rp  = rdf_inc(rx_rp, rx_pop);
      next_rx_cnt = rdf_count(rx_cnt, rx_push, rx_pop);
    end
    if (tx_clr) begin
      next_tx_wp  = '0;
      next_tx_rp  = '0;
      next_tx_cnt = `RDF_CNT_ZERO;
    end else begin
      next_tx_wp  = rdf_inc(tx_wp, tx_push);
      next_tx_rp  = rdf_inc(tx_rp, tx_pop);
      next_tx_cnt = rdf_count(tx_cnt, tx_push, tx_pop);
    end

    // Sticky errors; a new event wins over a flush in the same cycle
    next_rx_ovf = rx_ovf_ev || (rx_ovf && !rx_clr);
    next_tx_unf = tx_unf_ev || (tx_unf && !tx_clr);

    next_tx_valid = tx_pop;
    next_tx_data  = tx_pop ? tx_head : o_tx_rd_data;

    if (i_output_pin_signal_select == `RDF_SEL_RX_THR) begin
      next_gpo = rx_flag;
    end else if (i_output_pin_signal_select == `RDF_SEL_TX_THR) begin
      next_gpo = tx_flag;
    end else begin
      next_gpo = 1'b0;
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase         <= rdf_pkg::RDF_PH_HDR;
      bitcnt        <= `RDF_BIT_FIRST;
      sh_in         <= 8'h00;
      sh_out        <= 8'h00;
      is_read       <= 1'b0;
      is_fifo       <= 1'b0;
      is_burst      <= 1'b0;
      served        <= 1'b0;
      rx_wp         <= '0;
      rx_rp         <= '0;
      tx_wp         <= '0;
      tx_rp         <= '0;
      rx_cnt        <= `RDF_CNT_ZERO;
      tx_cnt        <= `RDF_CNT_ZERO;
      rx_ovf        <= 1'b0;
      tx_unf        <= 1'b0;
      o_tx_rd_data  <= 8'h00;
      o_tx_rd_valid <= 1'b0;
      o_general_purpose_output_pin <= 1'b0;
    end else begin
      phase         <= next_phase;
      bitcnt        <= next_bitcnt;
      sh_in         <= next_sh_in;
      sh_out        <= next_sh_out;
      is_read       <= next_is_read;
      is_fifo       <= next_is_fifo;
      is_burst      <= next_is_burst;
      served        <= next_served;
      rx_wp         <= next_rx_wp;
      rx_rp         <= next_rx_rp;
      tx_wp         <= next_tx_wp;
      tx_rp         <= next_tx_rp;
      rx_cnt        <= next_rx_cnt;
      tx_cnt        <= next_tx_cnt;
      rx_ovf        <= next_rx_ovf;
      tx_unf        <= next_tx_unf;
      o_tx_rd_data  <= next_tx_data;
      o_tx_rd_valid <= next_tx_valid;
      o_general_purpose_output_pin <= next_gpo;
    end
  end

  // ============================================================
  // Outputs
  assign o_so                  = sh_out[7];
  assign o_so_oe               = !csn_s2;
  assign o_receive_byte_count  = rx_cnt;
  assign o_transmit_byte_count = tx_cnt;
  assign o_rx_overflow         = rx_ovf;
  assign o_tx_underflow        = tx_unf;

endmodule : rdf_top

`default_nettype wire

// File: sim/rdf_top_properties.sv
`include "rdf_consts.svh"
`default_nettype none

module rdf_properties (
  input wire logic               i_clk,                        // Core clock
  input wire logic               i_rstn,                       // Reset, low
  input wire logic               i_csn,                        // Select pin
  input wire logic               o_so_oe,                      // Out enable
  input wire logic               i_rx_wr_valid,                // Modem write
  input wire logic               i_tx_rd_req,                  // Modem read
  input wire logic               i_rx_flush,                   // Rx flush
  input wire logic               i_tx_flush,                   // Tx flush
  input wire logic               i_sleep,                      // Sleep
  input wire logic [3:0]         i_threshold_select_field,     // Threshold
  input wire logic [5:0]         i_output_pin_signal_select,   // Pin select
  input wire logic               o_general_purpose_output_pin, // Pin
  input wire logic [`RDF_CW-1:0] o_receive_byte_count,         // Rx fill
  input wire logic [`RDF_CW-1:0] o_transmit_byte_count,        // Tx fill
  input wire logic               o_tx_rd_valid,                // Byte given
  input wire logic               o_rx_overflow,                // Overflow
  input wire logic               o_tx_underflow                // Underflow
);
  // ========
  // Thresholds from the select field
  logic [6:0] rx_thr;
  logic [6:0] tx_thr;
  assign rx_thr = {1'b0, i_threshold_select_field, 2'b00} + 7'h04;
  assign tx_thr = 7'h3d - {1'b0, i_threshold_select_field, 2'b00};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Flush and sleep outrank a modem request only in pointers and count
  sequence s_pop_ok;
    i_tx_rd_req && o_transmit_byte_count != 7'h00 &&
      !i_tx_flush && !i_sleep;
  endsequence
  sequence s_pop_dry;
    i_tx_rd_req && o_transmit_byte_count == 7'h00 &&
      !i_tx_flush && !i_sleep;
  endsequence

  // ========
  // Checks
  chk_pop_answer: assert property (
    s_pop_ok |=> o_tx_rd_valid)
    else $error("tx byte missing after request");
  chk_no_spur_valid: assert property (
    !i_tx_rd_req |=> !o_tx_rd_valid)
    else $error("tx byte given without request");
  chk_tx_underflow: assert property (
    s_pop_dry |=> o_tx_underflow && !o_tx_rd_valid)
    else $error("empty tx read not flagged");
  chk_rx_overflow: assert property (
    i_rx_wr_valid && o_receive_byte_count == 7'h40 &&
      !i_rx_flush && !i_sleep |=> o_rx_overflow)
    else $error("full rx write not flagged");
  chk_depth_cap: assert property (
    o_receive_byte_count <= 7'h40 && o_transmit_byte_count <= 7'h40)
    else $error("fill level above depth");
  chk_ovf_sticky: assert property (
    o_rx_overflow && !i_rx_flush && !i_sleep |=> o_rx_overflow)
    else $error("overflow flag dropped early");
  chk_unf_sticky: assert property (
    o_tx_underflow && !i_tx_flush && !i_sleep |=> $stable(o_tx_underflow))
    else $error("underflow flag dropped early");
  chk_rx_flush: assert property (
    i_rx_flush && !i_rx_wr_valid |=>
      o_receive_byte_count == 7'h00 && !o_rx_overflow)
    else $error("rx flush incomplete");
  chk_sleep_empty: assert property (
    i_sleep && !i_rx_wr_valid && !i_tx_rd_req |=>
      o_receive_byte_count == 7'h00 && o_transmit_byte_count == 7'h00 &&
      !o_rx_overflow && !o_tx_underflow)
    else $error("sleep kept buffer contents");
  chk_pin_rx: assert property (
    i_output_pin_signal_select == 6'h00 |=> o_general_purpose_output_pin ==
      ($past(o_receive_byte_count) >= $past(rx_thr)))
    else $error("rx threshold pin wrong");
  chk_pin_tx: assert property (
    i_output_pin_signal_select == 6'h02 |=> o_general_purpose_output_pin ==
      ($past(o_transmit_byte_count) >= $past(tx_thr)))
    else $error("tx threshold pin wrong");
  // Enable lags the select pin by the two synchroniser stages
  chk_oe_sync: assert property (
    o_so_oe == !$past(i_csn, 2))
    else $error("serial out enable wrong");
endmodule : rdf_properties

bind rdf_top rdf_properties u_props (
  .i_clk, .i_rstn, .i_csn, .o_so_oe, .i_rx_wr_valid, .i_tx_rd_req, .i_rx_flush,
  .i_tx_flush, .i_sleep, .i_threshold_select_field,
  .i_output_pin_signal_select, .o_general_purpose_output_pin,
  .o_receive_byte_count, .o_transmit_byte_count, .o_tx_rd_valid,
  .o_rx_overflow, .o_tx_underflow
);

`default_nettype wire

// File: sim/rdf_host.sv
`default_nettype none

module rdf_host (
  output logic      o_csn,  // Select, low
  output logic      o_sclk, // Serial clock
  output logic      o_si,   // Data to device
  input  wire logic i_so    // Data from device
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam realtime HALF = 62.5;
  logic [7:0] wbuf [64];
  logic [7:0] rbuf [64];

  // Clock idles low between frames
  initial begin
    o_csn = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end

  // ========
  // Mode 0 byte, MSB first
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si <= tx[i];
      #HALF o_sclk <= 1'b1;
      rx[i] = i_so;
      #HALF o_sclk <= 1'b0;
    end
  endtask : xbyte

  // Caller keeps n within fill level or free space
  task automatic frame(input logic rd, input logic bst, input int n,
                       output logic [7:0] st);
    o_csn <= 1'b0;
    #HALF xbyte({rd, bst, 6'h3f}, st);
    for (int i = 0; i < n; i++) begin
      xbyte(wbuf[i], rbuf[i]);
    end
    #HALF o_csn <= 1'b1;
    o_si <= ~o_si;
    #(4 * HALF);
  endtask : frame
endmodule : rdf_host

`default_nettype wire

// File: sim/rdf_top_tb.sv
`default_nettype none

module rdf_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, rstn, csn, sclk, si, so, wv, rq, tv, rfl, tfl, slp, pin;
  logic       ovf, unf, oe;
  logic [7:0] wd, td, st;
  logic [3:0] thr;
  logic [5:0] sel;
  logic [6:0] rxc, txc;
  int         n_errors = 0;
  int         n_tests = 0;

  rdf_top u_dut (
    .i_clk(clk), .i_rstn(rstn), .i_csn(csn), .i_sclk(sclk), .i_si(si),
    .o_so(so), .o_so_oe(oe), .i_rx_wr_valid(wv), .i_rx_wr_data(wd),
    .i_tx_rd_req(rq), .o_tx_rd_data(td), .o_tx_rd_valid(tv),
    .i_rx_flush(rfl), .i_tx_flush(tfl), .i_sleep(slp),
    .i_threshold_select_field(thr), .i_output_pin_signal_select(sel),
    .o_general_purpose_output_pin(pin), .o_receive_byte_count(rxc),
    .o_transmit_byte_count(txc), .o_rx_overflow(ovf), .o_tx_underflow(unf)
  );
  rdf_host u_host (.o_csn(csn), .o_sclk(sclk), .o_si(si), .i_so(so));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ========
  // Shared tasks
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic push(input logic [7:0] d);
    @(posedge clk);
    wv <= 1'b1;
    wd <= d;
    @(posedge clk);
    wv <= 1'b0;
  endtask : push

  task automatic pop(input logic [7:0] d, input logic ok);
    @(posedge clk);
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
    #1;
    check(tv === ok && (!ok || td === d), "tx byte");
  endtask : pop

  task automatic pulse_rst(input int which);
    @(posedge clk);
    rfl <= (which == 0);
    tfl <= (which == 1);
    slp <= (which == 2);
    @(posedge clk);
    {rfl, tfl, slp} <= 3'h0;
    #1;
  endtask : pulse_rst

  // All sixteen settings at one fill level
  task automatic sweep(input logic tx, input int c);
    int t;
    for (int s = 0; s < 16; s++) begin
      @(posedge clk);
      thr <= 4'(s);
      sel <= tx ? 6'h02 : 6'h00;
      repeat (2) @(posedge clk);
      #1;
      t = tx ? 61 - 4 * s : 4 * (s + 1);
      check(pin === (c >= t), "threshold pin");
    end
  endtask : sweep

  initial begin
    #400us;
    n_errors++;
    wrap_up();
  end

  // ========
  // Tests
  initial begin
    {rstn, wv, rq, rfl, tfl, slp} = 6'h00;
    wd = 8'h00;
    thr = 4'h0;
    sel = 6'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int c = 1; c <= 64; c++) begin
      push(8'(c * 3));
      sweep(1'b0, c);
      check(rxc === 7'(c), "rx count");
    end
    push(8'hee);
    #1;
    check(ovf === 1'b1 && rxc === 7'h40, "overflow");
    repeat (2) begin
      @(posedge clk);
      #1;
      check(rxc === 7'h40, "count poll");
    end
    u_host.frame(1'b1, 1'b1, 63, st);
    check(st === 8'h40, "rx status");
    for (int i = 0; i < 63; i++) begin
      check(u_host.rbuf[i] === 8'((i + 1) * 3), "rx data");
    end
    check(rxc === 7'h01 && ovf === 1'b1, "sticky overflow");
    pulse_rst(0);
    check(rxc === 7'h00 && ovf === 1'b0, "rx flush");
    for (int i = 0; i < 64; i++) begin
      u_host.wbuf[i] = 8'(255 - i);
    end
    u_host.frame(1'b0, 1'b1, 64, st);
    check(st === 8'h00 && txc === 7'h40, "tx fill");
    for (int i = 0; i < 64; i++) begin
      pop(8'(255 - i), 1'b1);
      sweep(1'b1, 63 - i);
      check(txc === 7'(63 - i), "tx count");
    end
    pop(8'h00, 1'b0);
    check(unf === 1'b1, "underflow");
    pulse_rst(1);
    check(unf === 1'b0, "tx flush");
    push(8'h11);
    push(8'h22);
    u_host.frame(1'b1, 1'b0, 2, st);
    check(st === 8'h02 && u_host.rbuf[0] === 8'h11, "single read");
    check(u_host.rbuf[1] === 8'h00 && rxc === 7'h01, "one per frame");
    u_host.frame(1'b0, 1'b1, 1, st);
    check(rxc === 7'h01 && txc === 7'h01, "before sleep");
    check(pin === 1'b1 && oe === 1'b0, "tx pin at one");
    @(posedge clk);
    sel <= 6'h01;
    repeat (2) @(posedge clk);
    #1;
    check(pin === 1'b0, "unused select");
    pulse_rst(2);
    check(rxc === 7'h00 && txc === 7'h00, "sleep");
    wrap_up();
  end
endmodule : rdf_top_tb

`default_nettype wire
